/* hdl/pin_sync.sv */
`timescale 1ns/1ns
`default_nettype none

// two-stage synchroniser for pin levels
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

`default_nettype wire

/* hdl/port_e_bus_control_pin_mux.sv */
// The implementer's own choice: register access over AHB-Lite.
`timescale 1ns/1ns
`default_nettype none

module port_e_bus_control_pin_mux (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	input  wire logic [2:0]  mode_strap,
	input  wire logic [7:0]  pe_pin_in,
	output logic      [7:0]  pe_pin_out,
	output logic      [7:0]  pe_pin_oe,
	output logic      [7:0]  pe_pullup_en,
	output logic      [7:0]  pd_pin_oe,
	output logic             pd_visible_data_en,
	input  wire logic        queue_status_1,
	input  wire logic        queue_status_0,
	input  wire logic        bus_e_clock,
	input  wire logic        low_byte_strobe,
	input  wire logic        read_write_line,
	input  wire logic        pll_test_clk,
	output logic             aux_reset_req,
	output logic             maskable_int_in,
	output logic             nonmaskable_int_in,
	output logic             e_clock_in,
	output logic             e_clock_free_run,
	output logic             ext_bus_access
);

	// ----------------------------------------
	// mode decode
	// ----------------------------------------
	logic special;
	logic periph;
	logic single;
	logic wide;
	logic expanded;
	logic norm_exp;
	logic norm_narrow;
	logic spec_narrow;

	assign special     = port_e_pkg::is_special(mode_strap);
	assign periph      = port_e_pkg::is_periph(mode_strap);
	assign single      = port_e_pkg::is_single(mode_strap);
	assign wide        = port_e_pkg::is_wide(mode_strap);
	assign expanded    = !single && !periph;
	assign norm_exp    = expanded && !special;
	assign norm_narrow = norm_exp && !wide;
	assign spec_narrow = expanded && special && !wide;

	// ----------------------------------------
	// state
	// ----------------------------------------
	logic        init_q;
	logic [7:0]  pd_dir_q;
	logic [7:0]  pe_data_q;
	logic [7:0]  pe_dir_q;
	logic [7:0]  assign_q;
	logic [3:0]  first_q;
	logic [2:0]  mode_ctrl_q;
	logic        pull_q;
	logic [7:0]  pe_sync;
	logic        dp_q;
	logic        dp_wr_q;
	logic        dp_word_q;
	logic        dp_present_q;
	logic        dp_ext_q;
	logic [5:0]  dp_idx_q;
	logic        rd_done_q;
	logic [31:0] hrdata_q;

	logic emulate_d;
	logic emulate_e;
	logic internal_visibility;
	assign emulate_d = mode_ctrl_q[port_e_pkg::EMULATE_D_BIT];
	assign emulate_e = mode_ctrl_q[port_e_pkg::EMULATE_E_BIT];
	assign internal_visibility      = mode_ctrl_q[port_e_pkg::INTERNAL_VISIBILITY_BIT];

	logic aux_reset_enable;
	logic pll_test_enable;
	logic queue_status_out_enable;
	logic no_e_clock;
	logic low_strobe_enable;
	logic rw_enable;
	assign aux_reset_enable = assign_q[port_e_pkg::AUX_RESET_ENABLE_BIT];
	assign pll_test_enable = assign_q[port_e_pkg::PLL_TEST_ENABLE_BIT];
	assign queue_status_out_enable = assign_q[port_e_pkg::QUEUE_STATUS_OUT_BIT];
	assign no_e_clock = assign_q[port_e_pkg::NO_E_CLOCK_BIT];
	assign low_strobe_enable = assign_q[port_e_pkg::LOW_STROBE_BIT];
	assign rw_enable  = assign_q[port_e_pkg::RW_ENABLE_BIT];

	// pin levels cross into the bus clock
	pin_sync #(
		.WIDTH (8)
	) u_pe_sync (
		.clk   (hclk),
		.rst_n (hresetn),
		.d     (pe_pin_in),
		.q     (pe_sync)
	);

	// ----------------------------------------
	// map presence
	// ----------------------------------------
	logic pd_gpio;
	logic pe_in_map;
	assign pd_gpio   = !periph && !(expanded && wide) && !(spec_narrow && emulate_d);
	assign pe_in_map = !periph && !(expanded && emulate_e);

	function automatic logic reg_known(input logic [5:0] idx);
		return idx == port_e_pkg::IDX_PD_DIR || idx == port_e_pkg::IDX_PE_DATA ||
			idx == port_e_pkg::IDX_PE_DIR || idx == port_e_pkg::IDX_PE_ASSIGN ||
			idx == port_e_pkg::IDX_MODE_CTRL || idx == port_e_pkg::IDX_PULL_CTRL;
	endfunction

	logic [5:0] ap_idx;
	logic       ap_present;
	assign ap_idx = haddr[port_e_pkg::IDX_LSB +: 6];

	// which on-chip registers answer in the current mode
	always_comb begin
		ap_present = 1'b0;
		if (haddr[31:8] == 24'h000000) begin
			unique case (ap_idx)
				port_e_pkg::IDX_PD_DIR:    ap_present = pd_gpio;
				port_e_pkg::IDX_PE_DATA:   ap_present = pe_in_map;
				port_e_pkg::IDX_PE_DIR:    ap_present = pe_in_map;
				port_e_pkg::IDX_PE_ASSIGN: ap_present = !periph;
				port_e_pkg::IDX_MODE_CTRL: ap_present = 1'b1;
				port_e_pkg::IDX_PULL_CTRL: ap_present = 1'b1;
				default:                   ap_present = 1'b0;
			endcase
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	logic accept;
	logic wr_go;
	logic rd_stall;
	assign accept    = hsel && hready && htrans[1] && init_q;
	assign rd_stall  = dp_q && !dp_wr_q && !rd_done_q;
	assign hreadyout = init_q && !rd_stall;
	assign wr_go     = dp_q && dp_wr_q && dp_word_q && dp_present_q && hreadyout;
	assign hrdata    = hrdata_q;
	assign hresp     = 1'b0;
	assign ext_bus_access = dp_q && dp_ext_q;

	// address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_q         <= 1'b0;
			dp_wr_q      <= 1'b0;
			dp_word_q    <= 1'b0;
			dp_present_q <= 1'b0;
			dp_ext_q     <= 1'b0;
			dp_idx_q     <= 6'h00;
		end else if (hreadyout) begin
			dp_q         <= accept;
			dp_wr_q      <= hwrite;
			dp_word_q    <= hsize == port_e_pkg::HSIZE_WORD;
			dp_present_q <= ap_present;
			dp_ext_q     <= accept && reg_known(ap_idx) && !ap_present;
			dp_idx_q     <= ap_idx;
		end
	end

	function automatic logic wr_hit(input logic go, input logic [5:0] a, input logic [5:0] b);
		return go && a == b;
	endfunction

	// read data: one wait state, then from a register
	logic [31:0] rd_val;
	logic [7:0]  pe_gpio_oe;
	always_comb begin
		rd_val = 32'h00000000;
		if (dp_present_q) begin
			unique case (dp_idx_q)
				port_e_pkg::IDX_PD_DIR:    rd_val[7:0] = pd_dir_q;
				port_e_pkg::IDX_PE_DATA:   rd_val[7:0] = (pe_data_q & pe_gpio_oe) |
					(pe_sync & ~pe_gpio_oe);
				port_e_pkg::IDX_PE_DIR:    rd_val[7:0] = pe_dir_q;
				port_e_pkg::IDX_PE_ASSIGN: rd_val[7:0] = assign_q & port_e_pkg::ASSIGN_MASK;
				port_e_pkg::IDX_MODE_CTRL: rd_val[2:0] = mode_ctrl_q;
				port_e_pkg::IDX_PULL_CTRL: rd_val[0]   = pull_q;
				default:                   rd_val = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_done_q <= 1'b0;
			hrdata_q  <= 32'h00000000;
		end else if (rd_stall) begin
			rd_done_q <= 1'b1;
			hrdata_q  <= rd_val;
		end else begin
			rd_done_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	// mode-dependent values load on the first edge after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			init_q <= 1'b0;
		end else begin
			init_q <= 1'b1;
		end
	end

	logic [7:0] pe_rst_val;
	logic [7:0] assign_rst_val;
	assign pe_rst_val = norm_narrow ? port_e_pkg::PE_RST_NORM_NARROW
		: port_e_pkg::PE_RST_OTHER;

	always_comb begin
		if (periph) begin
			assign_rst_val = port_e_pkg::ASSIGN_RST_PERIPH;
		end else if (special) begin
			assign_rst_val = port_e_pkg::ASSIGN_RST_SPECIAL;
		end else if (single) begin
			assign_rst_val = port_e_pkg::ASSIGN_RST_N_SCHIP;
		end else begin
			assign_rst_val = port_e_pkg::ASSIGN_RST_N_EXP;
		end
	end

	// port D and port E data and direction
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pd_dir_q  <= port_e_pkg::PD_DIR_RST;
			pe_data_q <= port_e_pkg::PE_RST_OTHER;
			pe_dir_q  <= port_e_pkg::PE_RST_OTHER;
		end else if (!init_q) begin
			pe_data_q <= pe_rst_val;
			pe_dir_q  <= pe_rst_val;
		end else begin
			if (wr_hit(wr_go, dp_idx_q, port_e_pkg::IDX_PD_DIR))
				pd_dir_q <= hwdata[7:0];
			if (wr_hit(wr_go, dp_idx_q, port_e_pkg::IDX_PE_DATA))
				pe_data_q <= hwdata[7:0];
			if (wr_hit(wr_go, dp_idx_q, port_e_pkg::IDX_PE_DIR))
				pe_dir_q <= hwdata[7:0];
		end
	end

	// assignment register with per-bit write rules
	logic       wr_assign;
	logic [7:0] wd;
	logic       once_ok;
	assign wr_assign = wr_hit(wr_go, dp_idx_q, port_e_pkg::IDX_PE_ASSIGN);
	assign wd        = hwdata[7:0];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			assign_q <= port_e_pkg::ASSIGN_RST_N_EXP;
			first_q  <= 4'h0;
		end else if (!init_q) begin
			assign_q <= assign_rst_val;
		end else if (wr_assign) begin
			first_q <= 4'hF;
			assign_q[port_e_pkg::AUX_RESET_ENABLE_BIT] <=
				wd[port_e_pkg::AUX_RESET_ENABLE_BIT];
			if (special && first_q[3])
				assign_q[port_e_pkg::PLL_TEST_ENABLE_BIT] <=
					wd[port_e_pkg::PLL_TEST_ENABLE_BIT];
			if (special ? first_q[2] : !first_q[2])
				assign_q[port_e_pkg::QUEUE_STATUS_OUT_BIT] <=
					wd[port_e_pkg::QUEUE_STATUS_OUT_BIT];
			if (!special)
				assign_q[port_e_pkg::NO_E_CLOCK_BIT] <=
					wd[port_e_pkg::NO_E_CLOCK_BIT];
			if (special ? first_q[1] : !first_q[1])
				assign_q[port_e_pkg::LOW_STROBE_BIT] <=
					wd[port_e_pkg::LOW_STROBE_BIT];
			if (special ? first_q[0] : !first_q[0])
				assign_q[port_e_pkg::RW_ENABLE_BIT] <=
					wd[port_e_pkg::RW_ENABLE_BIT];
		end
	end

	// mode control: own word, or second byte (hwdata[10:8]) of an assignment write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			mode_ctrl_q <= port_e_pkg::MODE_CTRL_RST;
			pull_q      <= port_e_pkg::PULL_RST;
		end else begin
			if (wr_hit(wr_go, dp_idx_q, port_e_pkg::IDX_MODE_CTRL))
				mode_ctrl_q <= hwdata[2:0];
			else if (wr_assign)
				mode_ctrl_q <= hwdata[port_e_pkg::MODE_SHIFT +: 3];
			if (wr_hit(wr_go, dp_idx_q, port_e_pkg::IDX_PULL_CTRL))
				pull_q <= hwdata[0];
		end
	end

	// ----------------------------------------
	// pin multiplexing
	// ----------------------------------------
	logic [7:0] alt_sel;
	logic [7:0] alt_oe;
	logic [7:0] alt_val;

	// alternate roles override the direction bits
	always_comb begin
		alt_sel = 8'h03;
		alt_oe  = 8'h00;
		alt_val = 8'h00;
		if (aux_reset_enable)
			alt_sel[7] = 1'b1;
		if (queue_status_out_enable && !single) begin
			alt_sel[6] = 1'b1;
			alt_oe[6]  = 1'b1;
			alt_val[6] = queue_status_1;
			alt_sel[5] = 1'b1;
			alt_oe[5]  = 1'b1;
			alt_val[5] = queue_status_0;
		end else if (pll_test_enable && !single && !norm_exp) begin
			alt_sel[6] = 1'b1;
			alt_oe[6]  = 1'b1;
			alt_val[6] = pll_test_clk;
		end
		if (!no_e_clock) begin
			alt_sel[4] = 1'b1;
			alt_oe[4]  = !periph;
			alt_val[4] = bus_e_clock;
		end
		if (low_strobe_enable && !single && !norm_narrow) begin
			alt_sel[3] = 1'b1;
			alt_oe[3]  = 1'b1;
			alt_val[3] = low_byte_strobe;
		end
		if (rw_enable && !single) begin
			alt_sel[2] = 1'b1;
			alt_oe[2]  = 1'b1;
			alt_val[2] = read_write_line;
		end
	end

	// before the first edge the reset values drive the pins
	logic [7:0] pe_dir_eff;
	logic [7:0] pe_data_eff;
	assign pe_dir_eff  = init_q ? pe_dir_q : pe_rst_val;
	assign pe_data_eff = init_q ? pe_data_q : pe_rst_val;
	assign pe_gpio_oe  = pe_dir_eff & ~alt_sel;
	assign pe_pin_oe   = pe_gpio_oe | alt_oe;
	assign pe_pin_out  = (alt_val & alt_sel) | (pe_data_eff & ~alt_sel);

	// pullups on inputs only; pin 1 always pulled
	assign pe_pullup_en = {4'h0, pull_q && !pe_pin_oe[3], pull_q && !pe_pin_oe[2],
		1'b1, pull_q};

	// port D direction and visibility data path
	assign pd_pin_oe          = pd_gpio ? pd_dir_q : 8'h00;
	assign pd_visible_data_en = spec_narrow && emulate_d;

	// ----------------------------------------
	// pin roles toward the core
	// ----------------------------------------
	assign aux_reset_req      = aux_reset_enable && pe_sync[7];
	assign maskable_int_in    = pe_sync[1];
	assign nonmaskable_int_in = pe_sync[0];
	assign e_clock_in         = periph && !no_e_clock && pe_sync[4];
	assign e_clock_free_run   = single && !no_e_clock && internal_visibility;

endmodule

`default_nettype wire

/* hdl/port_e_pkg.sv */
package port_e_pkg;

	// ----------------------------------------
	// register indexes (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [5:0] IDX_PD_DIR    = 6'h07;
	localparam logic [5:0] IDX_PE_DATA   = 6'h08;
	localparam logic [5:0] IDX_PE_DIR    = 6'h09;
	localparam logic [5:0] IDX_PE_ASSIGN = 6'h0A;
	localparam logic [5:0] IDX_MODE_CTRL = 6'h0B;
	localparam logic [5:0] IDX_PULL_CTRL = 6'h0C;
	localparam int         IDX_LSB       = 2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;

	// ----------------------------------------
	// operating modes
	// ----------------------------------------
	localparam logic [2:0] MODE_SPEC_SINGLE = 3'h0;
	localparam logic [2:0] MODE_SPEC_NARROW = 3'h1;
	localparam logic [2:0] MODE_PERIPHERAL  = 3'h2;
	localparam logic [2:0] MODE_SPEC_WIDE   = 3'h3;
	localparam logic [2:0] MODE_NORM_SINGLE = 3'h4;
	localparam logic [2:0] MODE_NORM_NARROW = 3'h5;
	localparam logic [2:0] MODE_NORM_WIDE   = 3'h7;

	// ----------------------------------------
	// assignment register fields
	// ----------------------------------------
	localparam int AUX_RESET_ENABLE_BIT = 7;
	localparam int PLL_TEST_ENABLE_BIT  = 6;
	localparam int QUEUE_STATUS_OUT_BIT = 5;
	localparam int NO_E_CLOCK_BIT       = 4;
	localparam int LOW_STROBE_BIT       = 3;
	localparam int RW_ENABLE_BIT        = 2;
	localparam logic [7:0] ASSIGN_MASK  = 8'hFC;

	// mode control fields, also at hwdata[10:8] of an assignment write
	localparam int EMULATE_D_BIT = 0;
	localparam int EMULATE_E_BIT = 1;
	localparam int INTERNAL_VISIBILITY_BIT      = 2;
	localparam int MODE_SHIFT    = 8;

	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [7:0] ASSIGN_RST_SPECIAL = 8'h2C;
	localparam logic [7:0] ASSIGN_RST_PERIPH  = 8'h50;
	localparam logic [7:0] ASSIGN_RST_N_SCHIP = 8'h10;
	localparam logic [7:0] ASSIGN_RST_N_EXP   = 8'h00;
	localparam logic [7:0] PE_RST_NORM_NARROW = 8'h08;
	localparam logic [7:0] PE_RST_OTHER       = 8'h00;
	localparam logic [7:0] PD_DIR_RST         = 8'h00;
	localparam logic [2:0] MODE_CTRL_RST      = 3'h0;
	localparam logic       PULL_RST           = 1'b0;

	// ----------------------------------------
	// mode decoding
	// ----------------------------------------
	function automatic logic is_special(input logic [2:0] m);
		return !m[2];
	endfunction

	function automatic logic is_periph(input logic [2:0] m);
		return m == MODE_PERIPHERAL;
	endfunction

	function automatic logic is_single(input logic [2:0] m);
		return m[1:0] == 2'h0;
	endfunction

	function automatic logic is_wide(input logic [2:0] m);
		return m[1:0] == 2'h3 || m == 3'h6;
	endfunction

endpackage

/* tb/ext_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none

// external parts on the port E pins
module ext_bus_model (
	input  wire logic [7:0] pe_pin_out,
	input  wire logic [7:0] pe_pin_oe,
	input  wire logic [7:0] ext_val,
	output logic      [7:0] pe_pin_in
);
	// device drive wins, elsewhere the outside part drives its level
	assign pe_pin_in = (pe_pin_out & pe_pin_oe) | (ext_val & ~pe_pin_oe);
endmodule

`default_nettype wire

/* tb/port_e_bus_control_pin_mux_tb.sv */
`timescale 1ns/1ns
`default_nettype none

module port_e_bus_control_pin_mux_tb;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [2:0]  mode_strap = 3'h0;
	logic [7:0]  ext_val = 8'h00;
	logic [5:0]  src_q = 6'h15;
	logic [31:0] rng = 32'h4B2C;
	logic        rd_ph = 1'b0;
	logic        hreadyout, aux_req, nmi_in, free_run;
	logic [31:0] hrdata;
	logic [7:0]  pe_pin_in, pe_pin_out, pe_pin_oe, pe_pullup_en, pd_pin_oe;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	int          err_count = 0;
	int          samples_checked = 0;

	// ----------------------------------------
	// clock, design and partner
	// ----------------------------------------
	always #25 hclk = ~hclk;

	// core bus-control sources keep moving
	always @(posedge hclk) src_q <= {src_q[4:0], src_q[5] ^ src_q[4]};

	port_e_bus_control_pin_mux dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(), .mode_strap(mode_strap),
		.pe_pin_in(pe_pin_in), .pe_pin_out(pe_pin_out), .pe_pin_oe(pe_pin_oe),
		.pe_pullup_en(pe_pullup_en), .pd_pin_oe(pd_pin_oe), .pd_visible_data_en(),
		.queue_status_1(src_q[0]), .queue_status_0(src_q[1]), .bus_e_clock(src_q[2]),
		.low_byte_strobe(src_q[3]), .read_write_line(src_q[4]), .pll_test_clk(src_q[5]),
		.aux_reset_req(aux_req), .maskable_int_in(), .nonmaskable_int_in(nmi_in), .e_clock_in(),
		.e_clock_free_run(free_run), .ext_bus_access()
	);

	ext_bus_model ext_u (.pe_pin_out(pe_pin_out), .pe_pin_oe(pe_pin_oe), .ext_val(ext_val),
		.pe_pin_in(pe_pin_in));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] rst_assign(input logic [2:0] m);
		case (m)
			3'h0, 3'h1, 3'h3: return 8'h2C;
			3'h2: return 8'h50;
			3'h4: return 8'h10;
			default: return 8'h00;
		endcase
	endfunction

	// write-once, except-first and never bits of the assignment register
	function automatic logic [7:0] nxt_assign(input logic [2:0] m, input logic [7:0] a,
		input logic [7:0] w, input logic first);
		logic [7:0] n;
		n = a;
		n[7] = w[7];
		if (m[2]) begin
			n[4] = w[4];
			if (first)
				{n[5], n[3], n[2]} = {w[5], w[3], w[2]};
		end else if (!first)
			{n[6], n[5], n[3], n[2]} = {w[6], w[5], w[3], w[2]};
		n[1:0] = 2'h0;
		return n;
	endfunction

	function automatic logic [7:0] roll();
		rng = {rng[30:0], rng[31] ^ rng[21] ^ rng[1] ^ rng[0]};
		return rng[7:0];
	endfunction

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one single word transfer, held until hready is seen high
	task automatic bus(input logic [5:0] idx, input logic wr, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, idx, 2'b00};
		hwrite <= wr;
		htrans <= 2'h2;
		hsize <= port_e_pkg::HSIZE_WORD;
		do @(posedge hclk); while (!hreadyout);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (!hreadyout);
	endtask

	task automatic wr(input logic [5:0] idx, input logic [7:0] v);
		bus(idx, 1'b1, {24'h0, v});
	endtask

	task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] msk);
		exp_q.push_back({24'h0, exp});
		msk_q.push_back({24'hFFFFFF, msk});
		bus(idx, 1'b0, 32'h0);
	endtask

	// read data phases end here: take the oldest note and compare
	always @(posedge hclk) begin
		if (rd_ph && hreadyout) begin
			rd_ph = 1'b0;
			chk_rd(hrdata & msk_q[0], exp_q[0] & msk_q[0]);
			void'(exp_q.pop_front());
			void'(msk_q.pop_front());
		end
		if (hsel && hreadyout && htrans[1] && !hwrite)
			rd_ph = 1'b1;
		if (!hresetn)
			rd_ph = 1'b0;
	end

	// ----------------------------------------
	// one reset and walk through a mode
	// ----------------------------------------
	task automatic run_mode(input logic [2:0] m);
		logic [7:0] a, w, d, p, q, v, drv;
		logic       per, sng;
		per = (m == port_e_pkg::MODE_PERIPHERAL);
		sng = (m[1:0] == 2'h0);
		hresetn <= 1'b0;
		mode_strap <= m;
		repeat (12) @(posedge hclk);
		if (m == port_e_pkg::MODE_NORM_NARROW)
			chk_pin({6'h0, pe_pin_oe[3], pe_pin_out[3]}, 8'h03);
		hresetn <= 1'b1;
		@(posedge hclk);
		a = rst_assign(m);
		rd(port_e_pkg::IDX_PE_ASSIGN, per ? 8'h00 : a, 8'hFF);
		rd(port_e_pkg::IDX_PE_DIR, m == 3'h5 ? 8'h08 : 8'h00, 8'hFF);
		for (int k = 0; k < 2; k++) begin
			w = roll();
			wr(port_e_pkg::IDX_PE_ASSIGN, w);
			if (!per)
				a = nxt_assign(m, a, w, k == 0);
			rd(port_e_pkg::IDX_PE_ASSIGN, per ? 8'h00 : a, 8'hFF);
		end
		d = roll();
		p = roll();
		q = roll();
		v = roll();
		ext_val <= v;
		wr(port_e_pkg::IDX_PE_DIR, d);
		wr(port_e_pkg::IDX_PE_DATA, p);
		wr(port_e_pkg::IDX_PD_DIR, q);
		wr(port_e_pkg::IDX_PULL_CTRL, 8'h01);
		repeat (3) @(posedge hclk);
		drv = d & {~a[7], 2'b11, a[4], 4'b1100};
		if (sng)
			rd(port_e_pkg::IDX_PE_DATA, (p & drv) | (v & ~drv),
				a[4] ? 8'hFF : 8'hEF);
		@(negedge hclk);
		if (sng) begin
			chk_pin(pe_pin_oe, drv | (a[4] ? 8'h00 : 8'h10));
			chk_pin(pe_pin_out & drv, p & drv);
			chk_pin(pe_pullup_en, {4'h0, ~drv[3], ~drv[2], 2'b11});
			chk_pin(pd_pin_oe, q);
			chk_pin({7'h0, aux_req}, {7'h0, a[7] & v[7]});
			chk_pin({7'h0, nmi_in}, {7'h0, v[0]});
		end else if (!per) begin
			chk_pin({7'h0, pe_pin_oe[2]}, {7'h0, a[2] | d[2]});
			if (a[2])
				chk_pin({7'h0, pe_pin_out[2]}, {7'h0, src_q[4]});
		end
		@(posedge hclk);
		wr(port_e_pkg::IDX_MODE_CTRL, 8'h07);
		rd(port_e_pkg::IDX_PE_DIR, sng ? d : 8'h00, 8'hFF);
		chk_pin({7'h0, free_run}, {7'h0, sng & ~a[4]});
		rd(port_e_pkg::IDX_PD_DIR, (sng || m == 3'h5) ? q : 8'h00, 8'hFF);
		rd(6'h3F, 8'h00, 8'hFF);
	endtask

	// ----------------------------------------
	// sequence, watchdog and verdict
	// ----------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		for (int i = 0; i < 8; i++)
			if (i != 6)
				run_mode(i[2:0]);
		give_verdict();
	end

	initial begin
		#500000;
		err_count++;
		give_verdict();
	end
endmodule

`default_nettype wire

/* tb/port_e_properties.sv */
`timescale 1ns/1ns
`default_nettype none

// watches bus answers and pin muxing of the port E block
module port_e_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [2:0]  mode_strap,
	input wire logic [7:0]  pe_pin_in,
	input wire logic [7:0]  pe_pin_out,
	input wire logic [7:0]  pe_pin_oe,
	input wire logic [7:0]  pe_pullup_en,
	input wire logic [7:0]  pd_pin_oe,
	input wire logic        pd_visible_data_en,
	input wire logic        maskable_int_in,
	input wire logic        e_clock_in,
	input wire logic        ext_bus_access
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic [1:0] up_q;

	// cycles since reset release, saturating
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			up_q <= 2'h0;
		else if (up_q != 2'h3)
			up_q <= up_q + 2'h1;
	end

	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_take;
		hsel && hready && htrans[1];
	endsequence
	sequence s_read_wait;
		!hreadyout ##1 hreadyout;
	endsequence

	property p_write_no_wait;
		s_take ##0 hwrite |=> hreadyout;
	endproperty
	property p_read_one_wait;
		s_take ##0 !hwrite |=> s_read_wait;
	endproperty
	property p_int_pins_input;
		pe_pin_oe[1:0] == 2'h0;
	endproperty
	property p_pullup_fixed;
		pe_pullup_en[1] && pe_pullup_en[7:4] == 4'h0;
	endproperty
	property p_pullup_inputs;
		(pe_pullup_en & pe_pin_oe & 8'h0D) == 8'h00;
	endproperty
	property p_irq_readable;
		up_q == 2'h3 |-> maskable_int_in == $past(pe_pin_in[1], 2);
	endproperty
	property p_narrow_pin3_high;
		$rose(hresetn) && mode_strap == port_e_pkg::MODE_NORM_NARROW |->
			pe_pin_oe[3] && pe_pin_out[3];
	endproperty
	property p_pd_visible;
		pd_visible_data_en |-> mode_strap == port_e_pkg::MODE_SPEC_NARROW && pd_pin_oe == 8'h00;
	endproperty
	property p_pd_wide_off;
		port_e_pkg::is_wide(mode_strap) || port_e_pkg::is_periph(mode_strap) |-> pd_pin_oe == 8'h00;
	endproperty
	property p_e_clock_dir;
		mode_strap != port_e_pkg::MODE_PERIPHERAL |-> !e_clock_in;
	endproperty
	property p_periph_absent;
		s_take ##0 (port_e_pkg::is_periph(mode_strap) && haddr[7:2] == port_e_pkg::IDX_PE_DATA)
			|=> ext_bus_access;
	endproperty

	a_write_no_wait: assert property (p_write_no_wait) else $error("write waited");
	a_read_one_wait: assert property (p_read_one_wait) else $error("read wait wrong");
	a_int_pins_input: assert property (p_int_pins_input) else $error("int pin driven");
	a_pullup_fixed: assert property (p_pullup_fixed) else $error("pullup wrong");
	a_pullup_inputs: assert property (p_pullup_inputs) else $error("pullup on output");
	a_irq_readable: assert property (p_irq_readable) else $error("pin 1 not seen");
	a_narrow_pin3_high: assert property (p_narrow_pin3_high) else $error("pin 3 low");
	a_pd_visible: assert property (p_pd_visible) else $error("port D visible wrong");
	a_pd_wide_off: assert property (p_pd_wide_off) else $error("port D driven");
	a_e_clock_dir: assert property (p_e_clock_dir) else $error("E clock input");
	a_periph_absent: assert property (p_periph_absent) else $error("data reg in map");
endmodule

bind port_e_bus_control_pin_mux port_e_checker chk_u (
	.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .mode_strap(mode_strap),
	.pe_pin_in(pe_pin_in), .pe_pin_out(pe_pin_out), .pe_pin_oe(pe_pin_oe),
	.pe_pullup_en(pe_pullup_en), .pd_pin_oe(pd_pin_oe), .pd_visible_data_en(pd_visible_data_en),
	.maskable_int_in(maskable_int_in), .e_clock_in(e_clock_in), .ext_bus_access(ext_bus_access)
);

`default_nettype wire
